// File: core/dvp_top.sv
// Display video output port: APB registers, raster syncs, pixel and video ports
//
// Notes on behaviour
// - Forward a pixel clock; pixel bus changes only while that clock is low.
// - When enabled, send 8-bit video bytes timed to the forwarded video clock.
// - Monitor horizontal sync sets line rate and horizontal retrace.
// - Monitor vertical sync sets refresh rate and vertical retrace.
// - Timing config bit 8 sets monitor horizontal sync polarity.
// - Timing config bit 9 sets monitor vertical sync polarity.
// - Separate panel horizontal sync, polarity from timing config bit 10.
// - Separate panel vertical sync, polarity from timing config bit 11.
// - Display active is high only during the visible part of each line.
// - Video valid is high only while the video bus holds a valid byte.
`timescale 1ns/10ps
module dvp_top import dvp_pkg::*; #(
	parameter int CNT_W = 12,
	parameter int H_ACTIVE = DVP_H_ACTIVE,
	parameter int H_SYNC_START = DVP_H_SYNC_START,
	parameter int H_SYNC_END = DVP_H_SYNC_END,
	parameter int H_TOTAL = DVP_H_TOTAL,
	parameter int V_ACTIVE = DVP_V_ACTIVE,
	parameter int V_SYNC_START = DVP_V_SYNC_START,
	parameter int V_SYNC_END = DVP_V_SYNC_END,
	parameter int V_TOTAL = DVP_V_TOTAL
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dot_clock_in,
	output logic pixel_clock_out,
	output logic [17:0] pixel_bus,
	output logic monitor_hsync,
	output logic monitor_vsync,
	output logic panel_hsync,
	output logic panel_vsync,
	output logic display_active,
	output logic video_port_clock,
	output logic [7:0] video_word_bus,
	output logic video_valid_out,
	input wire logic video_ready_in
);
	// ==========================================
	// State of the register side (pclk)
	typedef struct packed {
		logic [31:0] timing_cfg;
		logic [2:0] ctrl;
		logic [17:0] color;
		logic cfg_tgl;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [1:0] vclk_cnt;
		logic vclk;
		dvp_vstate_t vstate;
		logic [15:0] vword;
		logic [7:0] vbus;
		logic vvalid;
		logic xfer;
		logic rdy_s1;
		logic rdy_s2;
		logic vblank_s1;
		logic vblank_s2;
	} dvp_reg_state_t;

	// ==========================================
	// State of the pixel side (dot clock)
	typedef struct packed {
		logic tgl_s1;
		logic tgl_s2;
		logic tgl_seen;
		logic [3:0] pol;
		logic disp_en;
		logic [17:0] color;
		logic phase;
		logic [17:0] pixel;
		logic mon_hs;
		logic mon_vs;
		logic pnl_hs;
		logic pnl_vs;
		logic act;
		logic vblank;
	} dvp_dot_state_t;

	dvp_reg_state_t rs_r;
	dvp_reg_state_t rs_nxt;
	dvp_dot_state_t ds_r;
	dvp_dot_state_t ds_nxt;
	logic [1:0] dot_rst_r;
	logic dot_rst_n;
	logic setup;
	logic wr_en;
	logic hit;
	logic [31:0] rd_val;
	logic vrise;
	logic vfall;
	logic pix_step;
	logic h_wrap;
	logic h_act;
	logic h_sync;
	logic v_act;
	logic v_sync;

	// ==========================================
	// APB decode
	assign setup = psel && !penable;
	// Only the first access cycle writes; a master that lingers cannot write twice
	assign wr_en = psel && penable && rs_r.pready && pwrite && !rs_r.pslverr;
	assign vrise = (rs_r.vclk_cnt == DVP_VCLK_RISE_PH);
	assign vfall = (rs_r.vclk_cnt == DVP_VCLK_FALL_PH);

	always_comb begin
		hit = 1'b1;
		rd_val = 32'h0;
		case (paddr)
			DVP_TIMING_CFG_OFS: begin
				rd_val = rs_r.timing_cfg;
			end
			DVP_CTRL_OFS: begin
				rd_val = {29'h0, rs_r.ctrl};
			end
			DVP_WORD_OFS: begin
				rd_val = {16'h0, rs_r.vword};
			end
			DVP_STATUS_OFS: begin
				// Ready and blank are synchronised copies and lag their sources
				rd_val[DVP_ST_BUSY_BIT] = (rs_r.vstate != VS_IDLE);
				rd_val[DVP_ST_READY_BIT] = rs_r.rdy_s2;
				rd_val[DVP_ST_VBLANK_BIT] = rs_r.vblank_s2;
			end
			DVP_COLOR_OFS: begin
				rd_val = {14'h0, rs_r.color};
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// ==========================================
	// Register side next state
	always_comb begin
		rs_nxt = rs_r;
		rs_nxt.pready = setup;
		rs_nxt.pslverr = setup && !hit;
		if (setup) begin
			rs_nxt.prdata = pwrite ? 32'h0 : rd_val;
		end
		if (wr_en) begin
			case (paddr)
				DVP_TIMING_CFG_OFS: begin
					rs_nxt.timing_cfg = pwdata;
					rs_nxt.cfg_tgl = !rs_r.cfg_tgl;
				end
				DVP_CTRL_OFS: begin
					rs_nxt.ctrl = pwdata[2:0];
					rs_nxt.cfg_tgl = !rs_r.cfg_tgl;
				end
				DVP_COLOR_OFS: begin
					rs_nxt.color = pwdata[17:0];
					rs_nxt.cfg_tgl = !rs_r.cfg_tgl;
				end
				DVP_WORD_OFS: begin
					// A word offered while one is still moving is dropped
					if (rs_r.vstate == VS_IDLE && rs_r.ctrl[DVP_VID_EN_BIT]) begin
						rs_nxt.vword = pwdata[15:0];
						rs_nxt.vstate = VS_LOAD;
					end
				end
				default: begin
				end
			endcase
		end
		// Companion ready is a pin: two flops before use
		rs_nxt.rdy_s1 = video_ready_in;
		rs_nxt.rdy_s2 = rs_r.rdy_s1;
		rs_nxt.vblank_s1 = ds_r.vblank;
		rs_nxt.vblank_s2 = rs_r.vblank_s1;
		// Video clock runs at a quarter of pclk; rises after phase 1
		// Free running, so a new word may wait up to one video clock to start
		rs_nxt.vclk_cnt = rs_r.vclk_cnt + 2'h1;
		rs_nxt.vclk = rs_nxt.vclk_cnt[1];
		if (vrise) begin
			// Ready is taken at the rise; bus only moves at the next fall
			rs_nxt.xfer = rs_r.vvalid && rs_r.rdy_s2;
		end
		if (vfall) begin
			rs_nxt.xfer = 1'b0;
			case (rs_r.vstate)
				VS_IDLE: begin
					rs_nxt.vvalid = 1'b0;
					rs_nxt.vbus = 8'h0;
				end
				VS_LOAD: begin
					rs_nxt.vstate = VS_LOW;
					rs_nxt.vbus = rs_r.vword[7:0];
					rs_nxt.vvalid = 1'b1;
				end
				VS_LOW: begin
					if (rs_r.xfer) begin
						rs_nxt.vstate = VS_HIGH;
						rs_nxt.vbus = rs_r.vword[15:8];
					end
				end
				VS_HIGH: begin
					if (rs_r.xfer) begin
						rs_nxt.vstate = VS_IDLE;
						rs_nxt.vbus = 8'h0;
						rs_nxt.vvalid = 1'b0;
					end
				end
				default: begin
					rs_nxt.vstate = VS_IDLE;
				end
			endcase
			if (!rs_r.ctrl[DVP_VID_EN_BIT]) begin
				rs_nxt.vstate = VS_IDLE;
				rs_nxt.vbus = 8'h0;
				rs_nxt.vvalid = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rs_r <= '{timing_cfg: DVP_TIMING_CFG_RST, ctrl: DVP_CTRL_RST,
				color: DVP_COLOR_RST, vstate: VS_IDLE, default: '0};
		end else begin
			rs_r <= rs_nxt;
		end
	end

	// ==========================================
	// Pixel side reset: asserted at once, released on the dot clock
	always_ff @(posedge dot_clock_in or negedge presetn) begin
		if (!presetn) begin
			dot_rst_r <= 2'h0;
		end else begin
			dot_rst_r <= {dot_rst_r[0], 1'b1};
		end
	end
	assign dot_rst_n = dot_rst_r[1];

	// ==========================================
	// Raster counters; one pixel per two dot clocks
	// Clearing on disable restarts the frame at its first visible pixel
	assign pix_step = ds_r.phase && ds_r.disp_en;

	dvp_axis_cnt #(
		.W(CNT_W),
		.ACTIVE(H_ACTIVE),
		.SYNC_START(H_SYNC_START),
		.SYNC_END(H_SYNC_END),
		.TOTAL(H_TOTAL)
	) u_hcnt (
		.clk(dot_clock_in),
		.rst_n(dot_rst_n),
		.clear(!ds_r.disp_en),
		.step(pix_step),
		.wrap(h_wrap),
		.in_active(h_act),
		.in_sync(h_sync)
	);

	dvp_axis_cnt #(
		.W(CNT_W),
		.ACTIVE(V_ACTIVE),
		.SYNC_START(V_SYNC_START),
		.SYNC_END(V_SYNC_END),
		.TOTAL(V_TOTAL)
	) u_vcnt (
		.clk(dot_clock_in),
		.rst_n(dot_rst_n),
		.clear(!ds_r.disp_en),
		.step(h_wrap),
		.wrap(),
		.in_active(v_act),
		.in_sync(v_sync)
	);

	// ==========================================
	// Pixel side next state
	always_comb begin
		ds_nxt = ds_r;
		// Settings cross as a toggle; the held values are stable by then
		ds_nxt.tgl_s1 = rs_r.cfg_tgl;
		ds_nxt.tgl_s2 = ds_r.tgl_s1;
		ds_nxt.tgl_seen = ds_r.tgl_s2;
		// Limitation: writes closer than the toggle round trip merge into one update
		if (ds_r.tgl_s2 != ds_r.tgl_seen) begin
			ds_nxt.pol[0] = rs_r.timing_cfg[DVP_MON_HPOL_BIT];
			ds_nxt.pol[1] = rs_r.timing_cfg[DVP_MON_VPOL_BIT];
			ds_nxt.pol[2] = rs_r.timing_cfg[DVP_PNL_HPOL_BIT];
			ds_nxt.pol[3] = rs_r.timing_cfg[DVP_PNL_VPOL_BIT];
			ds_nxt.disp_en = rs_r.ctrl[DVP_DISP_EN_BIT];
			ds_nxt.color = rs_r.color;
		end
		ds_nxt.phase = !ds_r.phase;
		// Outputs move on the falling edge of the forwarded clock only
		if (ds_r.phase) begin
			ds_nxt.act = ds_r.disp_en && h_act && v_act;
			ds_nxt.pixel = ds_nxt.act ? ds_r.color : 18'h0;
			ds_nxt.mon_hs = (ds_r.disp_en && h_sync) ^ ds_r.pol[0];
			ds_nxt.mon_vs = (ds_r.disp_en && v_sync) ^ ds_r.pol[1];
			ds_nxt.pnl_hs = (ds_r.disp_en && h_sync) ^ ds_r.pol[2];
			ds_nxt.pnl_vs = (ds_r.disp_en && v_sync) ^ ds_r.pol[3];
			ds_nxt.vblank = !v_act;
		end
	end

	always_ff @(posedge dot_clock_in or negedge dot_rst_n) begin
		if (!dot_rst_n) begin
			ds_r <= '0;
		end else begin
			ds_r <= ds_nxt;
		end
	end

	// ==========================================
	// Outputs
	// Each output is a register field, so no logic sits between flop and pin
	assign prdata = rs_r.prdata;
	assign pready = rs_r.pready;
	assign pslverr = rs_r.pslverr;
	assign video_port_clock = rs_r.vclk;
	assign video_word_bus = rs_r.vbus;
	assign video_valid_out = rs_r.vvalid;
	assign pixel_clock_out = ds_r.phase;
	assign pixel_bus = ds_r.pixel;
	assign monitor_hsync = ds_r.mon_hs;
	assign monitor_vsync = ds_r.mon_vs;
	assign panel_hsync = ds_r.pnl_hs;
	assign panel_vsync = ds_r.pnl_vs;
	assign display_active = ds_r.act;
endmodule

// File: core/dvp_pkg.sv
// Shared constants and types for the display video output port
package dvp_pkg;
	// ==========================================
	// Register byte addresses
	localparam logic [15:0] DVP_TIMING_CFG_OFS = 16'h8308;
	localparam logic [15:0] DVP_CTRL_OFS = 16'h8310;
	localparam logic [15:0] DVP_WORD_OFS = 16'h8314;
	localparam logic [15:0] DVP_STATUS_OFS = 16'h8318;
	localparam logic [15:0] DVP_COLOR_OFS = 16'h831c;
	// ==========================================
	// Field positions
	localparam int DVP_MON_HPOL_BIT = 8;
	localparam int DVP_MON_VPOL_BIT = 9;
	localparam int DVP_PNL_HPOL_BIT = 10;
	localparam int DVP_PNL_VPOL_BIT = 11;
	localparam int DVP_DISP_EN_BIT = 0;
	localparam int DVP_VID_EN_BIT = 1;
	localparam int DVP_VID_FMT_BIT = 2;
	localparam int DVP_ST_BUSY_BIT = 0;
	localparam int DVP_ST_READY_BIT = 1;
	localparam int DVP_ST_VBLANK_BIT = 2;
	// ==========================================
	// Reset values
	localparam logic [31:0] DVP_TIMING_CFG_RST = 32'h0;
	localparam logic [2:0] DVP_CTRL_RST = 3'h0;
	localparam logic [17:0] DVP_COLOR_RST = 18'h0;
	// ==========================================
	// Raster defaults, in pixels and lines
	localparam int DVP_H_ACTIVE = 640;
	localparam int DVP_H_SYNC_START = 656;
	localparam int DVP_H_SYNC_END = 752;
	localparam int DVP_H_TOTAL = 800;
	localparam int DVP_V_ACTIVE = 480;
	localparam int DVP_V_SYNC_START = 490;
	localparam int DVP_V_SYNC_END = 492;
	localparam int DVP_V_TOTAL = 525;
	// ==========================================
	// Video port clock: pclk divided by four
	localparam logic [1:0] DVP_VCLK_RISE_PH = 2'h1;
	localparam logic [1:0] DVP_VCLK_FALL_PH = 2'h3;
	typedef enum logic [1:0] {
		VS_IDLE,
		VS_LOAD,
		VS_LOW,
		VS_HIGH
	} dvp_vstate_t;
endpackage

// File: core/dvp_axis_cnt.sv
// One raster axis counter with active and sync window flags
`timescale 1ns/10ps
module dvp_axis_cnt import dvp_pkg::*; #(
	parameter int W = 12,
	parameter int ACTIVE = DVP_H_ACTIVE,
	parameter int SYNC_START = DVP_H_SYNC_START,
	parameter int SYNC_END = DVP_H_SYNC_END,
	parameter int TOTAL = DVP_H_TOTAL
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic step,
	output logic wrap,
	output logic in_active,
	output logic in_sync
);
	typedef struct packed {
		logic [W-1:0] pos;
	} dvp_cnt_state_t;

	localparam logic [W-1:0] LAST = W'(TOTAL - 1);
	localparam logic [W-1:0] ACT_END = W'(ACTIVE);
	localparam logic [W-1:0] SS = W'(SYNC_START);
	localparam logic [W-1:0] SE = W'(SYNC_END);

	dvp_cnt_state_t st_r;
	dvp_cnt_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (clear) begin
			st_nxt.pos = '0;
		end else if (step) begin
			st_nxt.pos = (st_r.pos == LAST) ? '0 : st_r.pos + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign wrap = step && (st_r.pos == LAST);
	assign in_active = (st_r.pos < ACT_END);
	assign in_sync = (st_r.pos >= SS) && (st_r.pos < SE);
endmodule

// File: bench/dvp_top_assertions.sv
// Pin-level checks on the display video output port
`timescale 1ns/10ps
module dvp_top_assertions #(
	parameter int H_ACTIVE = 640,
	parameter int H_SYNC_START = 656,
	parameter int H_SYNC_END = 752
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic dot_clock_in,
	input wire logic pixel_clock_out,
	input wire logic [17:0] pixel_bus,
	input wire logic monitor_hsync,
	input wire logic monitor_vsync,
	input wire logic panel_hsync,
	input wire logic panel_vsync,
	input wire logic display_active,
	input wire logic video_port_clock,
	input wire logic [7:0] video_word_bus,
	input wire logic video_valid_out
);
	// One pixel lasts two dot clocks
	localparam int HS_DLY = 2 * (H_SYNC_START - H_ACTIVE);
	localparam int HS_W = 2 * (H_SYNC_END - H_SYNC_START);
	// ==========================================
	// Pixel side
	AST_PIX_EDGE: assert property (@(posedge dot_clock_in) disable iff (!presetn)
		$changed(pixel_bus) |-> $fell(pixel_clock_out)) else $error("pixel bus moved off fall");
	AST_PIX_BLANK: assert property (@(posedge dot_clock_in) disable iff (!presetn)
		!display_active |-> pixel_bus == 18'h0) else $error("pixel bus not blank");
	AST_MON_HS: assert property (@(posedge dot_clock_in) disable iff (!presetn)
		$fell(display_active) |-> ##HS_DLY $changed(monitor_hsync) ##HS_W $changed(monitor_hsync))
		else $error("monitor hsync timing");
	AST_PNL_HS: assert property (@(posedge dot_clock_in) disable iff (!presetn)
		$fell(display_active) |-> ##HS_DLY $changed(panel_hsync) ##HS_W $changed(panel_hsync))
		else $error("panel hsync timing");
	AST_MON_VS: assert property (@(posedge dot_clock_in) disable iff (!presetn)
		$changed(monitor_vsync) |-> !$past(display_active)) else $error("monitor vsync in view");
	AST_PNL_VS: assert property (@(posedge dot_clock_in) disable iff (!presetn)
		$changed(panel_vsync) |-> !$past(display_active)) else $error("panel vsync in view");
	// ==========================================
	// Video and register side
	AST_VID_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(video_word_bus) |-> $fell(video_port_clock)) else $error("video bus off fall");
	AST_VID_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		!video_valid_out |-> video_word_bus == 8'h0) else $error("video bus not idle");
	AST_APB_ANS: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready) else $error("no answer after setup");
endmodule

bind dvp_top dvp_top_assertions #(.H_ACTIVE(H_ACTIVE), .H_SYNC_START(H_SYNC_START),
	.H_SYNC_END(H_SYNC_END)) dvp_top_assertions_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .dot_clock_in(dot_clock_in),
	.pixel_clock_out(pixel_clock_out), .pixel_bus(pixel_bus), .monitor_hsync(monitor_hsync),
	.monitor_vsync(monitor_vsync), .panel_hsync(panel_hsync), .panel_vsync(panel_vsync),
	.display_active(display_active), .video_port_clock(video_port_clock),
	.video_word_bus(video_word_bus), .video_valid_out(video_valid_out));

// File: bench/dvp_companion.sv
// Companion chip model: dot clock source and video byte sink
`timescale 1ns/10ps
module dvp_companion (
	input wire logic stall,
	input wire logic video_port_clock,
	input wire logic [7:0] video_word_bus,
	input wire logic video_valid_out,
	output logic dot_clock_in,
	output logic video_ready_in,
	output logic [15:0] last_word,
	output logic [7:0] word_cnt
);
	logic hi_half = 1'b0;
	initial begin
		dot_clock_in = 1'b0;
		video_ready_in = 1'b0;
		last_word = 16'h0;
		word_cnt = 8'h0;
	end
	always #24 dot_clock_in = ~dot_clock_in;
	// Ready moves only just after a rise, so the sender never sees it mid-change
	always @(posedge video_port_clock) begin
		if (video_valid_out && video_ready_in) begin
			if (hi_half) begin
				last_word[15:8] <= video_word_bus;
				word_cnt <= word_cnt + 8'h1;
			end else begin
				last_word[7:0] <= video_word_bus;
			end
			hi_half <= ~hi_half;
		end
		video_ready_in <= ~stall;
	end
endmodule

// File: bench/test_display_video_output_port.sv
// Self-checking bench for the display video output port
`timescale 1ns/10ps
module test_display_video_output_port import dvp_pkg::*;;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0;
	logic stall = 1'b0;
	logic pol;
	logic perr;
	logic [31:0] prdata;
	logic [31:0] r;
	logic pready, pslverr, dot_clock_in, pixel_clock_out, monitor_hsync, monitor_vsync;
	logic panel_hsync, panel_vsync, display_active, video_port_clock, video_valid_out;
	logic video_ready_in;
	logic [17:0] pixel_bus;
	logic [7:0] video_word_bus;
	logic [7:0] word_cnt;
	logic [7:0] cnt0;
	logic [15:0] last_word;
	int error_cnt = 0;
	int compares = 0;
	wire logic [2:0] watch = {monitor_vsync, monitor_hsync, display_active};
	always #12.5 pclk = ~pclk;
	dvp_top #(.V_ACTIVE(4), .V_SYNC_START(5), .V_SYNC_END(6), .V_TOTAL(8)) dvp_top_inst (
		.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dot_clock_in(dot_clock_in), .pixel_clock_out(pixel_clock_out), .pixel_bus(pixel_bus),
		.monitor_hsync(monitor_hsync), .monitor_vsync(monitor_vsync), .panel_hsync(panel_hsync),
		.panel_vsync(panel_vsync), .display_active(display_active),
		.video_port_clock(video_port_clock), .video_word_bus(video_word_bus),
		.video_valid_out(video_valid_out), .video_ready_in(video_ready_in));
	dvp_companion dvp_companion_inst (.stall(stall), .video_port_clock(video_port_clock),
		.video_word_bus(video_word_bus), .video_valid_out(video_valid_out),
		.dot_clock_in(dot_clock_in), .video_ready_in(video_ready_in), .last_word(last_word),
		.word_cnt(word_cnt));
	// ==========================================
	// Tasks
	task automatic final_report();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		if (n == 50) error_cnt++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rdchk(input string s, input logic [15:0] a, input logic [31:0] x, input logic xe);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(s, x, r);
		chk(s, {31'h0, xe}, {31'h0, e});
	endtask
	// Bounded wait on one of the observed pins, judged at falling dot edges where pins settle
	task automatic wait_bit(input int i, input logic v);
		int n;
		n = 0;
		while (watch[i] !== v && n < 20000) begin
			n++;
			@(negedge dot_clock_in);
		end
		if (n == 20000) error_cnt++;
	endtask
	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge dot_clock_in);
		@(posedge pclk);
		presetn <= 1'b1;
	endtask
	// ==========================================
	// Tests: both polarity settings, each after its own reset
	initial begin
		#2000000;
		error_cnt++;
		final_report();
	end
	initial begin
		for (int p = 0; p < 2; p++) begin
			pol = p[0];
			do_reset();
			rdchk("timing reset", DVP_TIMING_CFG_OFS, DVP_TIMING_CFG_RST, 1'b0);
			rdchk("unmapped", 16'h8300, 32'h0, 1'b1);
			wr(DVP_TIMING_CFG_OFS, {20'h5a5a5, {4{pol}}, 8'h3c});
			rdchk("timing rw", DVP_TIMING_CFG_OFS, {20'h5a5a5, {4{pol}}, 8'h3c}, 1'b0);
			repeat (10) @(posedge pclk);
			wr(DVP_COLOR_OFS, 32'h2a5c3);
			repeat (10) @(posedge pclk);
			wr(DVP_CTRL_OFS, 32'h3);
			wait_bit(0, 1'b1);
			chk("pixel", 32'h2a5c3, {14'h0, pixel_bus});
			chk("mon hs idle", {31'h0, pol}, {31'h0, monitor_hsync});
			chk("mon vs idle", {31'h0, pol}, {31'h0, monitor_vsync});
			chk("pnl hs idle", {31'h0, pol}, {31'h0, panel_hsync});
			chk("pnl vs idle", {31'h0, pol}, {31'h0, panel_vsync});
			wait_bit(1, ~pol);
			chk("pnl hs pulse", {31'h0, ~pol}, {31'h0, panel_hsync});
			chk("active in hs", 32'h0, {31'h0, display_active});
			wait_bit(2, ~pol);
			chk("pnl vs pulse", {31'h0, ~pol}, {31'h0, panel_vsync});
			chk("active in vs", 32'h0, {31'h0, display_active});
			cnt0 = word_cnt;
			stall <= 1'b1;
			wr(DVP_WORD_OFS, 32'hbe00 + p);
			wr(DVP_WORD_OFS, 32'h5555);
			rdchk("busy", DVP_STATUS_OFS, 32'h5, 1'b0);
			repeat (40) @(posedge pclk);
			chk("stalled", {24'h0, cnt0}, {24'h0, word_cnt});
			stall <= 1'b0;
			for (int n = 0; n < 100 && r[DVP_ST_BUSY_BIT] !== 1'b0; n++) begin
				apb(1'b0, DVP_STATUS_OFS, 32'h0, r, perr);
			end
			chk("idle", 32'h0, {31'h0, r[DVP_ST_BUSY_BIT]});
			chk("poll err", 32'h0, {31'h0, perr});
			chk("word", 32'hbe00 + p, {16'h0, last_word});
			chk("count", {24'h0, cnt0 + 8'h1}, {24'h0, word_cnt});
		end
		final_report();
	end
endmodule
